//--- shep_pkg.sv
package shep_pkg;
  // clock and serial link timing
  localparam int unsigned SYS_CLK_NS     = 25;
  localparam int unsigned SCLK_PERIOD_NS = 1000;
  localparam logic [15:0] SCLK_HALF_CYC  =
    16'((SCLK_PERIOD_NS / 2 + SYS_CLK_NS - 1) / SYS_CLK_NS);
  // cycles after reset release before the mode pins are taken
  localparam logic [2:0]  STRAP_WAIT_CYC = 3'h4;

  // register image held by the device
  localparam int          REG_COUNT      = 8;
  localparam int          REG_AW         = 3;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  // serial frame layout
  localparam logic [7:0]  CMD_WRITE      = 8'h02;
  localparam logic [7:0]  CMD_READ       = 8'h03;
  localparam logic [6:0]  BOOT_HDR_BITS  = 7'h10;
  localparam logic [6:0]  BOOT_BITS      = 7'h50;
  localparam logic [4:0]  EE_HDR_BITS    = 5'h10;
  localparam logic [4:0]  SPI_FRAME_BITS = 5'h18;
  localparam logic [4:0]  I2C_FRAME_BITS = 5'h1B;
  localparam logic [6:0]  I2C_DEV_ADDR   = 7'h5A;
  localparam logic [7:0]  EE_SEED        = 8'hA0;

  // sampled pin idle level {mosi, miso, select, sclk}
  localparam logic [3:0]  PIN_IDLE       = 4'hF;

  // mode pin encoding on {pin1, pin0}; anything else is spi slave
  localparam logic [1:0]  STRAP_I2C      = 2'h0;
  localparam logic [1:0]  STRAP_SPI_MST  = 2'h1;

  typedef enum logic [1:0] {MODE_SPI_SLAVE, MODE_I2C_SLAVE, MODE_SPI_MASTER} shep_mode_type;
endpackage

//--- shep_port_if.sv
`timescale 1ns/1ps
interface shep_port_if;
  // device end drives
  logic dev_sclk_o;
  logic dev_sclk_oe_n;
  logic dev_sel_o;
  logic dev_sel_oe_n;
  logic dev_miso_o;
  logic dev_miso_oe_n;
  logic dev_mosi_o;
  logic dev_mosi_oe_n;
  // far end drives
  logic host_sclk_o;
  logic host_sclk_oe_n;
  logic host_sel_o;
  logic host_sel_oe_n;
  logic host_miso_o;
  logic host_miso_oe_n;
  logic host_mosi_o;
  logic host_mosi_oe_n;
  // wire levels; an undriven line rests high through the board pull-up
  logic sclk;
  logic spi_select_n;
  logic miso;
  logic mosi;
  assign sclk         = (dev_sclk_oe_n | dev_sclk_o) & (host_sclk_oe_n | host_sclk_o);
  assign spi_select_n = (dev_sel_oe_n | dev_sel_o) & (host_sel_oe_n | host_sel_o);
  assign miso         = (dev_miso_oe_n | dev_miso_o) & (host_miso_oe_n | host_miso_o);
  assign mosi         = (dev_mosi_oe_n | dev_mosi_o) & (host_mosi_oe_n | host_mosi_o);

  modport dev (
    output dev_sclk_o, dev_sclk_oe_n, dev_sel_o, dev_sel_oe_n,
    output dev_miso_o, dev_miso_oe_n, dev_mosi_o, dev_mosi_oe_n,
    input  sclk, spi_select_n, miso, mosi
  );
  modport host (
    output host_sclk_o, host_sclk_oe_n, host_sel_o, host_sel_oe_n,
    output host_miso_o, host_miso_oe_n, host_mosi_o, host_mosi_oe_n,
    input  sclk, spi_select_n, miso, mosi
  );
endinterface // shep_port_if

//--- shep_host.sv
`timescale 1ns/1ps
module shep_host
  import shep_pkg::*;
(
  // system
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // serial port pins
  shep_port_if.host              port,
  // strap and role selection
  input  wire logic              strap_en,
  input  wire logic [1:0]        strap_val,
  input  wire logic              use_i2c,
  input  wire logic              eeprom_en,
  // register access requests
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [REG_AW-1:0] req_addr,
  input  wire logic [7:0]        req_data,
  output logic                   busy,
  output logic                   done,
  output logic [7:0]             rd_data,
  output logic                   i2c_nak
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_STOP} shep_hstate_type;

  logic [3:0]      pin_s1_reg;
  logic [3:0]      pin_s2_reg;
  logic [3:0]      pin_s3_reg;
  shep_hstate_type h_state_reg;
  logic [15:0]     h_half_reg;
  logic [4:0]      h_bit_reg;
  logic [4:0]      h_len_reg;
  logic            h_i2c_reg;
  logic            h_scl_reg;
  logic            h_sel_n_reg;
  logic            h_sda_reg;
  logic [26:0]     h_tx_reg;
  logic [26:0]     h_rx_reg;
  logic [4:0]      e_cnt_reg;
  logic [2:0]      e_sub_reg;
  logic [7:0]      e_shift_reg;
  logic [7:0]      e_addr_reg;
  logic [7:0]      e_tx_reg;
  logic            e_drive_reg;
  logic            e_miso_reg;
  logic            tick;
  logic            in_bit;
  logic            sclk_rise;
  logic            sclk_fall;
  logic [7:0]      e_byte_in;

  // pins come from the device's domain, two flops before any use
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= PIN_IDLE;
      pin_s2_reg <= PIN_IDLE;
      pin_s3_reg <= PIN_IDLE;
    end
    else
    begin
      pin_s1_reg <= {port.mosi, port.miso, port.spi_select_n, port.sclk};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign sclk_rise = pin_s2_reg[0] & ~pin_s3_reg[0];
  assign sclk_fall = ~pin_s2_reg[0] & pin_s3_reg[0];
  assign tick      = h_half_reg == SCLK_HALF_CYC - 16'h1;
  assign in_bit    = h_i2c_reg ? pin_s2_reg[3] : pin_s2_reg[2];
  assign e_byte_in = {e_shift_reg[6:0], pin_s2_reg[3]};

  // bus master: one spi register frame or one i2c write frame per request
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_state_reg <= H_IDLE;
      h_half_reg  <= 16'h0;
      h_bit_reg   <= 5'h0;
      h_len_reg   <= 5'h0;
      h_i2c_reg   <= 1'b0;
      h_scl_reg   <= 1'b1;
      h_sel_n_reg <= 1'b1;
      h_sda_reg   <= 1'b1;
      h_tx_reg    <= 27'h0;
      h_rx_reg    <= 27'h0;
      busy        <= 1'b0;
      done        <= 1'b0;
      rd_data     <= 8'h00;
      i2c_nak     <= 1'b0;
    end
    else
    begin
      h_half_reg <= (h_state_reg == H_IDLE || tick) ? 16'h0 : h_half_reg + 16'h1;
      done       <= 1'b0;
      case (h_state_reg)
        H_IDLE:
        begin
          h_scl_reg   <= use_i2c; // spi idles low, i2c idles high
          h_sda_reg   <= 1'b1;
          h_sel_n_reg <= 1'b1;
          if (req_valid && !eeprom_en && !strap_en)
          begin
            h_i2c_reg   <= use_i2c;
            h_bit_reg   <= 5'h0;
            busy        <= 1'b1;
            h_state_reg <= H_START;
            h_len_reg   <= use_i2c ? I2C_FRAME_BITS : SPI_FRAME_BITS;
            if (use_i2c)
              h_tx_reg <= {I2C_DEV_ADDR, 1'b0, 1'b1, 5'h00, req_addr, 1'b1, req_data, 1'b1};
            else
              h_tx_reg <= {req_write ? CMD_WRITE : CMD_READ, 5'h00, req_addr, req_data, 3'h0};
          end
        end
        H_START:
        begin
          if (h_i2c_reg)
            h_sda_reg <= 1'b0;
          else
            h_sel_n_reg <= 1'b0;
          if (tick)
          begin
            h_scl_reg   <= 1'b0;
            h_sda_reg   <= h_tx_reg[26];
            h_tx_reg    <= {h_tx_reg[25:0], 1'b0};
            h_state_reg <= H_LOW;
          end
        end
        H_LOW:
          if (tick)
          begin
            h_scl_reg   <= 1'b1;
            h_state_reg <= H_HIGH;
          end
        H_HIGH:
          if (tick)
          begin
            h_scl_reg <= 1'b0;
            h_rx_reg  <= {h_rx_reg[25:0], in_bit};
            h_bit_reg <= h_bit_reg + 5'h1;
            if (h_bit_reg == h_len_reg - 5'h1)
            begin
              h_sda_reg   <= 1'b0;
              h_state_reg <= H_STOP;
            end
            else
            begin
              h_sda_reg   <= h_tx_reg[26];
              h_tx_reg    <= {h_tx_reg[25:0], 1'b0};
              h_state_reg <= H_LOW;
            end
          end
        H_STOP:
          if (tick)
          begin
            if (h_i2c_reg && !h_scl_reg)
              h_scl_reg <= 1'b1;
            else
            begin
              h_sda_reg   <= 1'b1;
              h_sel_n_reg <= 1'b1;
              busy        <= 1'b0;
              done        <= 1'b1;
              rd_data     <= h_rx_reg[7:0];
              i2c_nak     <= h_i2c_reg & (h_rx_reg[18] | h_rx_reg[9] | h_rx_reg[0]);
              h_state_reg <= H_IDLE;
            end
          end
        default: h_state_reg <= H_IDLE;
      endcase
    end
  end

  // serial eeprom responder: ignores the command, streams seed plus address
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      e_cnt_reg   <= 5'h0;
      e_sub_reg   <= 3'h0;
      e_shift_reg <= 8'h00;
      e_addr_reg  <= 8'h00;
      e_tx_reg    <= 8'h00;
      e_drive_reg <= 1'b0;
      e_miso_reg  <= 1'b1;
    end
    else if (!eeprom_en || pin_s2_reg[1])
    begin
      e_cnt_reg   <= 5'h0;
      e_sub_reg   <= 3'h0;
      e_drive_reg <= 1'b0;
    end
    else if (sclk_rise)
    begin
      e_shift_reg <= e_byte_in;
      if (e_cnt_reg != EE_HDR_BITS)
        e_cnt_reg <= e_cnt_reg + 5'h1;
      if (e_cnt_reg == EE_HDR_BITS - 5'h1)
      begin
        e_addr_reg  <= e_byte_in;
        e_tx_reg    <= e_byte_in + EE_SEED;
        e_drive_reg <= 1'b1;
      end
      else if (e_cnt_reg == EE_HDR_BITS)
      begin
        e_sub_reg <= e_sub_reg + 3'h1;
        if (e_sub_reg == 3'h7)
        begin
          e_addr_reg <= e_addr_reg + 8'h01;
          e_tx_reg   <= e_addr_reg + 8'h01 + EE_SEED;
        end
      end
    end
    else if (sclk_fall && e_drive_reg)
    begin
      e_miso_reg <= e_tx_reg[7];
      e_tx_reg   <= {e_tx_reg[6:0], 1'b0};
    end
  end

  // pin drivers; select is left to the board pull-up outside strapping and spi slave use
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port.host_sclk_o    <= 1'b1;
      port.host_sclk_oe_n <= 1'b1;
      port.host_sel_o     <= 1'b1;
      port.host_sel_oe_n  <= 1'b1;
      port.host_miso_o    <= 1'b1;
      port.host_miso_oe_n <= 1'b1;
      port.host_mosi_o    <= 1'b1;
      port.host_mosi_oe_n <= 1'b1;
    end
    else
    begin
      port.host_sclk_o    <= 1'b1;
      port.host_sclk_oe_n <= 1'b1;
      port.host_sel_o     <= 1'b1;
      port.host_sel_oe_n  <= 1'b1;
      port.host_miso_o    <= 1'b1;
      port.host_miso_oe_n <= 1'b1;
      port.host_mosi_o    <= 1'b1;
      port.host_mosi_oe_n <= 1'b1;
      if (strap_en)
      begin
        port.host_sel_o     <= strap_val[0];
        port.host_sel_oe_n  <= 1'b0;
        port.host_miso_o    <= strap_val[1];
        port.host_miso_oe_n <= 1'b0;
      end
      else if (eeprom_en)
      begin
        port.host_miso_o    <= e_miso_reg;
        port.host_miso_oe_n <= ~e_drive_reg;
      end
      else if (use_i2c)
      begin
        port.host_sclk_o    <= 1'b0;
        port.host_sclk_oe_n <= h_scl_reg;
        port.host_mosi_o    <= 1'b0;
        port.host_mosi_oe_n <= h_sda_reg;
      end
      else
      begin
        port.host_sclk_o    <= h_scl_reg;
        port.host_sclk_oe_n <= 1'b0;
        port.host_sel_o     <= h_sel_n_reg;
        port.host_sel_oe_n  <= 1'b0;
        port.host_mosi_o    <= h_sda_reg;
        port.host_mosi_oe_n <= 1'b0;
      end
    end
  end
endmodule // shep_host

//--- shep_device.sv
`timescale 1ns/1ps
module shep_device
  import shep_pkg::*;
(
  // system
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // serial port pins
  shep_port_if.dev               port,
  // user side
  input  wire logic [REG_AW-1:0] cfg_idx,
  output logic [7:0]             cfg_data,
  output shep_mode_type          mode,
  output logic                   config_ready
);
  typedef enum logic [1:0] {ST_STRAP, ST_BOOT, ST_RUN} shep_state_type;

  logic [3:0]      pin_s1_reg;
  logic [3:0]      pin_s2_reg;
  logic [3:0]      pin_s3_reg;
  shep_state_type  state_reg;
  logic [2:0]      strap_cnt_reg;
  logic [7:0]      cfg_mem [REG_COUNT];
  logic [15:0]     b_half_reg;
  logic [6:0]      b_bit_reg;
  logic            b_sclk_reg;
  logic            b_sel_n_reg;
  logic [15:0]     b_tx_reg;
  logic [7:0]      b_rx_reg;
  logic [2:0]      s_cnt_reg;
  logic [1:0]      s_byte_reg;
  logic [7:0]      s_shift_reg;
  logic [7:0]      s_cmd_reg;
  logic [2:0]      s_addr_reg;
  logic [7:0]      s_tx_reg;
  logic            s_rd_reg;
  logic            s_miso_reg;
  logic [3:0]      i_bit_reg;
  logic [1:0]      i_byte_reg;
  logic            i_act_reg;
  logic            i_ack_reg;
  logic [7:0]      i_shift_reg;
  logic [2:0]      i_addr_reg;
  logic            sclk_rise;
  logic            sclk_fall;
  logic            sel_s;
  logic            miso_s;
  logic            mosi_s;
  logic            i2c_start;
  logic            i2c_stop;
  logic            boot_tick;
  logic            boot_done;
  logic            boot_we;
  logic [6:0]      boot_ofs;
  logic            spi_slv;
  logic            spi_we;
  logic [7:0]      s_byte_in;
  logic [2:0]      s_addr_next;
  logic            i2c_slv;
  logic            i2c_we;

  // pins come from the far end's domain, two flops before any use
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_reg <= PIN_IDLE;
      pin_s2_reg <= PIN_IDLE;
      pin_s3_reg <= PIN_IDLE;
    end
    else
    begin
      pin_s1_reg <= {port.mosi, port.miso, port.spi_select_n, port.sclk};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // edges and line levels; the same pins serve i2c as scl and sda
  assign sclk_rise = pin_s2_reg[0] & ~pin_s3_reg[0];
  assign sclk_fall = ~pin_s2_reg[0] & pin_s3_reg[0];
  assign sel_s     = pin_s2_reg[1];
  assign miso_s    = pin_s2_reg[2];
  assign mosi_s    = pin_s2_reg[3];
  assign i2c_start = pin_s3_reg[3] & ~pin_s2_reg[3] & pin_s2_reg[0] & pin_s3_reg[0];
  assign i2c_stop  = ~pin_s3_reg[3] & pin_s2_reg[3] & pin_s2_reg[0] & pin_s3_reg[0];

  // mode strap: caught by the clock only once the synchroniser has settled
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= ST_STRAP;
      mode          <= MODE_SPI_SLAVE;
      strap_cnt_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        ST_STRAP:
        begin
          strap_cnt_reg <= strap_cnt_reg + 3'h1;
          if (strap_cnt_reg == STRAP_WAIT_CYC)
          begin
            state_reg <= ST_RUN;
            case ({miso_s, sel_s})
              STRAP_I2C: mode <= MODE_I2C_SLAVE;
              STRAP_SPI_MST:
              begin
                mode      <= MODE_SPI_MASTER;
                state_reg <= ST_BOOT;
              end
              default: mode <= MODE_SPI_SLAVE;
            endcase
          end
        end
        ST_BOOT:
          if (boot_done)
            state_reg <= ST_RUN;
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_STRAP;
      endcase
    end
  end

  // eeprom boot: read command, address zero, then the whole register image
  assign boot_tick = (state_reg == ST_BOOT) && (b_half_reg == SCLK_HALF_CYC - 16'h1);
  assign boot_done = boot_tick & b_sclk_reg & (b_bit_reg == BOOT_BITS - 7'h1);
  assign boot_ofs  = b_bit_reg - BOOT_HDR_BITS;
  assign boot_we   = boot_tick & b_sclk_reg & (b_bit_reg >= BOOT_HDR_BITS)
                     & (b_bit_reg[2:0] == 3'h7);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      b_half_reg  <= 16'h0;
      b_bit_reg   <= 7'h0;
      b_sclk_reg  <= 1'b0;
      b_sel_n_reg <= 1'b1;
      b_tx_reg    <= {CMD_READ, 8'h00};
      b_rx_reg    <= 8'h00;
    end
    else if (state_reg != ST_BOOT)
      b_half_reg <= 16'h0;
    else
    begin
      b_half_reg <= boot_tick ? 16'h0 : b_half_reg + 16'h1;
      if (boot_tick)
      begin
        if (b_sel_n_reg)
          b_sel_n_reg <= 1'b0;
        else if (!b_sclk_reg)
        begin
          b_sclk_reg <= 1'b1;
          b_rx_reg   <= {b_rx_reg[6:0], miso_s};
        end
        else
        begin
          b_sclk_reg <= 1'b0;
          b_tx_reg   <= {b_tx_reg[14:0], 1'b0};
          b_bit_reg  <= b_bit_reg + 7'h1;
          if (b_bit_reg == BOOT_BITS - 7'h1)
            b_sel_n_reg <= 1'b1;
        end
      end
    end
  end

  // spi slave: command byte, address byte, then data with auto-increment
  assign spi_slv     = (state_reg == ST_RUN) && (mode == MODE_SPI_SLAVE);
  assign s_byte_in   = {s_shift_reg[6:0], mosi_s};
  assign s_addr_next = s_addr_reg + 3'h1;
  assign spi_we      = spi_slv & ~sel_s & sclk_rise & (s_cnt_reg == 3'h7)
                       & (s_byte_reg == 2'h2) & (s_cmd_reg == CMD_WRITE);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_cnt_reg   <= 3'h0;
      s_byte_reg  <= 2'h0;
      s_shift_reg <= 8'h00;
      s_cmd_reg   <= 8'h00;
      s_addr_reg  <= 3'h0;
      s_tx_reg    <= 8'h00;
      s_rd_reg    <= 1'b0;
      s_miso_reg  <= 1'b1;
    end
    else if (!spi_slv || sel_s)
    begin
      s_cnt_reg  <= 3'h0;
      s_byte_reg <= 2'h0;
      s_rd_reg   <= 1'b0;
    end
    else if (sclk_rise)
    begin
      s_shift_reg <= s_byte_in;
      s_cnt_reg   <= s_cnt_reg + 3'h1;
      if (s_cnt_reg == 3'h7)
      begin
        if (s_byte_reg != 2'h2)
          s_byte_reg <= s_byte_reg + 2'h1;
        case (s_byte_reg)
          2'h0: s_cmd_reg <= s_byte_in;
          2'h1:
          begin
            s_addr_reg <= s_byte_in[REG_AW-1:0];
            s_tx_reg   <= cfg_mem[s_byte_in[REG_AW-1:0]];
            s_rd_reg   <= (s_cmd_reg == CMD_READ);
          end
          default:
          begin
            s_addr_reg <= s_addr_next;
            s_tx_reg   <= cfg_mem[s_addr_next];
          end
        endcase
      end
    end
    else if (sclk_fall && s_rd_reg)
    begin
      s_miso_reg <= s_tx_reg[7];
      s_tx_reg   <= {s_tx_reg[6:0], 1'b0};
    end
  end

  // i2c slave, write only: address byte, register byte, data with increment
  assign i2c_slv = (state_reg == ST_RUN) && (mode == MODE_I2C_SLAVE);
  assign i2c_we  = i2c_slv & i_act_reg & sclk_fall & (i_bit_reg == 4'h8)
                   & ~i_ack_reg & (i_byte_reg == 2'h2);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i_bit_reg   <= 4'h0;
      i_byte_reg  <= 2'h0;
      i_act_reg   <= 1'b0;
      i_ack_reg   <= 1'b0;
      i_shift_reg <= 8'h00;
      i_addr_reg  <= 3'h0;
    end
    else if (!i2c_slv || i2c_stop)
    begin
      i_act_reg <= 1'b0;
      i_ack_reg <= 1'b0;
    end
    else if (i2c_start)
    begin
      i_act_reg  <= 1'b1;
      i_ack_reg  <= 1'b0;
      i_bit_reg  <= 4'h0;
      i_byte_reg <= 2'h0;
    end
    else if (i_act_reg && sclk_rise && i_bit_reg != 4'h8)
    begin
      i_shift_reg <= {i_shift_reg[6:0], mosi_s};
      i_bit_reg   <= i_bit_reg + 4'h1;
    end
    else if (i_act_reg && sclk_fall && i_bit_reg == 4'h8)
    begin
      if (i_ack_reg)
      begin
        i_ack_reg <= 1'b0;
        i_bit_reg <= 4'h0;
        if (i_byte_reg != 2'h2)
          i_byte_reg <= i_byte_reg + 2'h1;
      end
      else
      begin
        case (i_byte_reg)
          2'h0:
            if (i_shift_reg == {I2C_DEV_ADDR, 1'b0})
              i_ack_reg <= 1'b1;
            else
              i_act_reg <= 1'b0;
          2'h1:
          begin
            i_addr_reg <= i_shift_reg[REG_AW-1:0];
            i_ack_reg  <= 1'b1;
          end
          default:
          begin
            i_addr_reg <= i_addr_reg + 3'h1;
            i_ack_reg  <= 1'b1;
          end
        endcase
      end
    end
  end

  // register image; the three writers never run in the same mode
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        cfg_mem[i] <= REG_RESET;
    end
    else if (boot_we)
      cfg_mem[boot_ofs[5:3]] <= b_rx_reg;
    else if (spi_we)
      cfg_mem[s_addr_reg] <= s_byte_in;
    else if (i2c_we)
      cfg_mem[i_addr_reg] <= i_shift_reg;
  end

  // pin drivers, one cycle behind the engines to keep outputs on flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port.dev_sclk_o    <= 1'b1;
      port.dev_sclk_oe_n <= 1'b1;
      port.dev_sel_o     <= 1'b1;
      port.dev_sel_oe_n  <= 1'b1;
      port.dev_miso_o    <= 1'b1;
      port.dev_miso_oe_n <= 1'b1;
      port.dev_mosi_o    <= 1'b1;
      port.dev_mosi_oe_n <= 1'b1;
      cfg_data           <= REG_RESET;
      config_ready       <= 1'b0;
    end
    else
    begin
      port.dev_sclk_o    <= b_sclk_reg;
      port.dev_sclk_oe_n <= state_reg != ST_BOOT;
      port.dev_sel_o     <= b_sel_n_reg;
      port.dev_sel_oe_n  <= state_reg != ST_BOOT;
      port.dev_miso_o    <= s_miso_reg;
      port.dev_miso_oe_n <= ~(spi_slv & ~sel_s & s_rd_reg);
      port.dev_mosi_o    <= (state_reg == ST_BOOT) ? b_tx_reg[15] : 1'b0;
      port.dev_mosi_oe_n <= ~((state_reg == ST_BOOT) | (i2c_slv & i_ack_reg));
      cfg_data           <= cfg_mem[cfg_idx];
      config_ready       <= state_reg == ST_RUN;
    end
  end
endmodule // shep_device

//--- shep_checker.sv
`timescale 1ns/1ps
// watches the shared pins; every check runs on the device clock
module shep_checker (
  // system
  input wire logic sys_clk,
  input wire logic rst_n,
  // wire levels
  input wire logic sclk,
  input wire logic spi_select_n,
  input wire logic mosi,
  // device enables
  input wire logic dev_sclk_oe_n,
  input wire logic dev_sel_oe_n,
  input wire logic dev_miso_oe_n,
  input wire logic dev_mosi_oe_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // pins stay inputs while the mode straps are still being read
  sequence s_sel_quiet;
    dev_sel_oe_n [*5];
  endsequence
  sequence s_miso_quiet;
    dev_miso_oe_n [*5];
  endsequence
  // half period of the boot clock is 20 cycles, so 8 is a safe floor
  sequence s_sclk_high;
    sclk [*8];
  endsequence
  a_sel_input: assert property ($rose(rst_n) |-> s_sel_quiet)
    else $error("select driven during strap window");
  a_miso_input: assert property ($rose(rst_n) |-> s_miso_quiet)
    else $error("data out driven during strap window");
  a_miso_read: assert property ($fell(dev_miso_oe_n) |-> !spi_select_n)
    else $error("data out driven without select");
  // select and its enable flip on the same flop edge, so look one cycle back
  a_sel_release: assert property (
    $rose(spi_select_n) && !$past(dev_sel_oe_n) |-> ##[0:80] dev_sel_oe_n)
    else $error("select not released after boot");
  // while the device clocks the eeprom it only listens on data out
  a_sclk_owner: assert property (!dev_sclk_oe_n |-> dev_miso_oe_n)
    else $error("clock and data out driven together");
  a_sclk_half: assert property ($rose(sclk) && !dev_sclk_oe_n |-> s_sclk_high)
    else $error("boot clock high phase too short");
  a_mosi_hold: assert property (
    !dev_sclk_oe_n && !spi_select_n && sclk && $past(sclk) |-> $stable(mosi))
    else $error("boot data moved while clock high");
  a_ack_scl_low: assert property ($fell(dev_mosi_oe_n) && dev_sel_oe_n |-> !sclk)
    else $error("ack started while clock high");
endmodule // shep_checker

//--- serial_host_and_eeprom_port_bench.sv
`timescale 1ns/1ps
module serial_host_and_eeprom_port_bench import shep_pkg::*;;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              strap_en, use_i2c, eeprom_en, req_valid, req_write;
  logic              busy, done, i2c_nak, config_ready;
  logic [1:0]        strap_val;
  logic [REG_AW-1:0] req_addr, cfg_idx;
  logic [7:0]        req_data, rd_data, cfg_data;
  shep_mode_type     mode;
  int                fail_count = 0;
  int                comparisons = 0;
  shep_port_if port_if ();
  shep_device shep_device_inst (.sys_clk, .rst_n, .port(port_if.dev), .cfg_idx, .cfg_data,
    .mode, .config_ready);
  shep_host shep_host_inst (.sys_clk, .rst_n, .port(port_if.host), .strap_en, .strap_val,
    .use_i2c, .eeprom_en, .req_valid, .req_write, .req_addr, .req_data, .busy, .done,
    .rd_data, .i2c_nak);
  shep_checker shep_checker_inst (.sys_clk, .rst_n, .sclk(port_if.sclk),
    .spi_select_n(port_if.spi_select_n), .mosi(port_if.mosi),
    .dev_sclk_oe_n(port_if.dev_sclk_oe_n), .dev_sel_oe_n(port_if.dev_sel_oe_n),
    .dev_miso_oe_n(port_if.dev_miso_oe_n), .dev_mosi_oe_n(port_if.dev_mosi_oe_n));
  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;
  task tick;
    @(posedge sys_clk);
    #2;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // straps held well past the device sampling point, then released
  task start(input logic [1:0] s, input logic ee);
    int n;
    rst_n = 1'b0;
    strap_en = 1'b1;
    strap_val = s;
    eeprom_en = ee;
    use_i2c = (s == STRAP_I2C);
    repeat (4) tick;
    rst_n = 1'b1;
    repeat (10) tick;
    strap_en = 1'b0;
    n = 0;
    while (config_ready !== 1'b1 && n < 5000)
    begin
      tick;
      n++;
    end
    chk({7'h0, config_ready}, 8'h01);
  endtask
  task xfer(input logic w, input logic [REG_AW-1:0] a, input logic [7:0] d);
    int n;
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_data = d;
    tick;
    req_valid = 1'b0;
    chk({7'h0, busy}, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      tick;
      n++;
    end
    chk({7'h0, done}, 8'h01);
    chk({7'h0, busy}, 8'h00);
    tick;
  endtask
  task peek(input logic [REG_AW-1:0] a, input logic [7:0] exp);
    cfg_idx = a;
    tick;
    tick;
    chk(cfg_data, exp);
  endtask
  task wrap_up;
    $display("mismatches %0d, comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // main sequence: spi slave, eeprom boot, then i2c slave
  initial
  begin
    {strap_en, use_i2c, eeprom_en, req_valid, req_write, strap_val} = 7'h00;
    {req_addr, cfg_idx, req_data} = 14'h0000;
    start(2'h3, 1'b0);
    chk({6'h0, mode}, {6'h0, MODE_SPI_SLAVE});
    xfer(1'b1, 3'h7, 8'h5A);
    xfer(1'b1, 3'h0, 8'hA5);
    xfer(1'b0, 3'h7, 8'h00);
    chk(rd_data, 8'h5A);
    peek(3'h7, 8'h5A);
    peek(3'h0, 8'hA5);
    peek(3'h3, REG_RESET);
    start(STRAP_SPI_MST, 1'b1);
    chk({6'h0, mode}, {6'h0, MODE_SPI_MASTER});
    chk({7'h0, port_if.dev_sel_oe_n}, 8'h01);
    chk({7'h0, port_if.spi_select_n}, 8'h01);
    for (int i = 0; i < REG_COUNT; i++)
      peek(REG_AW'(i), EE_SEED + 8'(i));
    start(STRAP_I2C, 1'b0);
    chk({6'h0, mode}, {6'h0, MODE_I2C_SLAVE});
    xfer(1'b1, 3'h2, 8'hC3);
    chk({7'h0, i2c_nak}, 8'h00);
    peek(3'h2, 8'hC3);
    wrap_up;
  end
  // bound far above the roughly 7.5k cycles the tests need
  initial
  begin
    #1000000;
    fail_count++;
    wrap_up;
  end
endmodule // serial_host_and_eeprom_port_bench
